// >>> rtl/adc_port_pkg.sv
// constants, field layout and types shared by both ends of the converter parallel port
//
// Contract
// - unipolar codes straight binary, bipolar two's complement
// - data driven only while select and read low; here the drive starts and ends one clock after them
// - low byte read gives result bits 7..0
// - high byte read: bit 8 on pin 0, 9 on 1
// - high byte upper pins zero or sign fill
// - control byte: mode, acquisition, single, unipolar, channel
// - single-ended: channel N positive, common return negative
// - pseudo-differential: pair from bits 2:1, bit 0 polarity
// - inputs 4..7 only on eight-channel build
// - reset: external clock mode, done output high
// - host waits 10 us reset before converting
// - power-down modes keep port alive, no conversions
// - standby exits on next write strobe rising edge
// - shutdown entered only after running conversion completes
// - write strobe rising edge leaves shutdown
// - host waits 500/50 us settling, in standby
// - host enters standby by a dummy standby write
// - 10-bit result, 1024 codes per reference span
// - mode field: 00 down, 01 standby, 10/11 normal
// - control byte latched from pins 7..0 on write
// - select high ignores strobes, data pins released
package adc_port_pkg;

   // port and result widths
   localparam int           DataBits      = 8;
   localparam int           ResultBits    = 10;
   localparam int           CodeLevels    = 1024;
   localparam int           NumInputs     = 8;

   // control byte field positions
   localparam int           PwrModeHiPos  = 7;
   localparam int           PwrModeLoPos  = 6;
   localparam int           AcqModePos    = 5;
   localparam int           SinglePos     = 4;
   localparam int           UnipolarPos   = 3;
   localparam int           ChanHiPos     = 2;
   localparam int           ChanLoPos     = 0;

   // power and clock mode codes
   localparam logic [1:0]   PwrFullDown   = 2'h0;
   localparam logic [1:0]   PwrStandby    = 2'h1;
   localparam logic [1:0]   PwrNormIntClk = 2'h2;
   localparam logic [1:0]   PwrNormExtClk = 2'h3;

   // reset values and channel masks of the device end
   localparam logic         ExtClockReset = 1'b1;
   localparam logic         DoneNReset    = 1'b1;
   localparam logic [7:0]   FourChanMask  = 8'h0f;
   localparam logic [7:0]   EightChanMask = 8'hff;

   // timing, at the 50 MHz system clock
   localparam int           ClockMhz       = 50;
   localparam int           ResetWaitUs    = 10;
   localparam int           SettleIntRefUs = 500;
   localparam int           SettleExtRefUs = 50;
   localparam int           ResetWaitCycles  = ResetWaitUs * ClockMhz;
   localparam int           SettleIntCycles  = SettleIntRefUs * ClockMhz;
   localparam int           SettleExtCycles  = SettleExtRefUs * ClockMhz;
   localparam int           StrobeCycles     = 2;

   // host controller register map
   localparam int           RegAddrBits   = 4;
   localparam int           RegDataBits   = 16;
   localparam logic [3:0]   RegCtrl       = 4'h0;
   localparam logic [3:0]   RegStatus     = 4'h4;
   localparam logic [3:0]   RegResult     = 4'h8;
   localparam int           StatBusyPos   = 0;
   localparam int           StatValidPos  = 1;
   localparam int           StatSettlePos = 2;
   localparam logic [7:0]   StandbyByte   = 8'h40;

   // host sequencer states
   typedef enum logic [2:0] {
      H_RESET, H_WRITE, H_SETTLE, H_IDLE, H_WAIT, H_READ_LO, H_READ_HI
   } host_state_e;

endpackage : adc_port_pkg

// >>> rtl/adc_port_if.sv
// parallel port wires between the converter and its host
`timescale 1ns/1ps
interface adc_port_if;
   logic       csN;
   logic       wrN;
   logic       rdN;
   logic       highByteSel;
   logic [7:0] hostData;
   logic       hostDataOe;
   logic [7:0] devData;
   logic       devDataOe;
   logic       intN;
   logic [7:0] busData;

   // resolved bus level; released bus reads as pulled up
   assign busData = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);

   modport device (input csN, wrN, rdN, highByteSel, busData,
                   output devData, devDataOe, intN);
   modport host   (output csN, wrN, rdN, highByteSel, hostData, hostDataOe,
                   input busData, intN);
endinterface : adc_port_if

// >>> rtl/adc_port_device.sv
// converter end: control byte decode, power modes, input routing and result readout
`timescale 1ns/1ps
module adc_port_device
   import adc_port_pkg::*;
#(
   parameter bit EightChannel = 1'b1
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // parallel port
   adc_port_if.device       port,
   // analog core control
   output logic             convStart,
   output logic             extClock,
   output logic             acqExternal,
   output logic             standby,
   output logic             shutdown,
   output logic [7:0]       posSel,
   output logic [7:0]       negSel,
   output logic             negCommon,
   // analog core answer
   input  wire logic        coreDone,
   input  wire logic [9:0]  coreCode
);

   typedef struct packed {
      logic       wrSeen;
      logic [7:0] wrByte;
      logic       busy;
      logic       shutPending;
      logic       standby;
      logic       shutdown;
      logic       extClock;
      logic       acqExt;
      logic       unipolar;
      logic [9:0] result;
      logic       resUnipolar;
      logic       intN;
      logic [7:0] dataOut;
      logic       dataOe;
      logic       convStart;
      logic [7:0] posSel;
      logic [7:0] negSel;
      logic       negCommon;
   } dev_state_s;

   localparam dev_state_s ResetState = '{extClock: ExtClockReset,
                                         intN:     DoneNReset,
                                         default:  '0};
   localparam logic [7:0] ChanMask = EightChannel ? EightChanMask : FourChanMask;

   dev_state_s s;
   dev_state_s next_s;

   // strobes count only while the chip is selected
   logic       wrActive;
   logic       wrRise;
   logic       rdActive;
   logic [1:0] newMode;
   logic [2:0] newChan;
   logic [2:0] evenIn;
   logic [2:0] posIdx;
   logic [2:0] negIdx;
   logic [9:0] codedResult;
   logic [7:0] highByte;
   logic [7:0] lowByte;

   assign wrActive = !port.csN && !port.wrN;
   assign rdActive = !port.csN && !port.rdN;
   // end of a write: strobe or select released after a low write
   assign wrRise   = s.wrSeen && !wrActive;

   // control byte fields of the latched byte
   assign newMode  = s.wrByte[PwrModeHiPos:PwrModeLoPos];
   assign newChan  = s.wrByte[ChanHiPos:ChanLoPos];

   // pair base is the even input; bit 0 picks which one is positive
   assign evenIn   = {newChan[2:1], 1'b0};
   assign posIdx   = newChan[0] ? (evenIn | 3'h1) : evenIn;
   assign negIdx   = newChan[0] ? evenIn : (evenIn | 3'h1);

   // the core hands over an offset-binary code; bipolar flips the msb
   assign codedResult = s.unipolar ? coreCode
                                   : {~coreCode[9], coreCode[8:0]};

   // readout bytes from the held result
   assign lowByte  = s.result[7:0];
   assign highByte = s.resUnipolar ? {6'h00, s.result[9:8]}
                                   : {{6{s.result[9]}}, s.result[9:8]};

   // next-state logic
   always_comb begin
      next_s           = s;
      next_s.convStart = 1'b0;
      next_s.wrSeen    = wrActive;

      // sample the byte on the pins throughout the low write strobe
      if (wrActive) begin
         next_s.wrByte = port.busData;
      end

      // the port stays alive in every power mode
      next_s.dataOe = rdActive;
      if (rdActive) begin
         next_s.dataOut = port.highByteSel ? highByte : lowByte;
         next_s.intN    = 1'b1;
      end

      // conversion finished: latch result and the coding it used
      if (s.busy && coreDone) begin
         next_s.busy        = 1'b0;
         next_s.result      = codedResult;
         next_s.resUnipolar = s.unipolar;
         next_s.intN        = 1'b0;
         if (s.shutPending) begin
            next_s.shutPending = 1'b0;
            next_s.shutdown    = 1'b1;
         end
      end

      // completed write: any edge wakes the part, then the byte decides
      // writes other than a full power-down byte during a running conversion are dropped so the held
      // result and the routing of that conversion stay consistent
      if (wrRise && !s.busy) begin
         next_s.standby  = 1'b0;
         next_s.shutdown = 1'b0;
         next_s.acqExt   = s.wrByte[AcqModePos];
         next_s.unipolar = s.wrByte[UnipolarPos];
         case (newMode)
            PwrFullDown: begin
               next_s.shutdown = 1'b1;
            end
            PwrStandby: begin
               next_s.standby  = 1'b1;
            end
            PwrNormIntClk, PwrNormExtClk: begin
               next_s.extClock  = newMode[0];
               next_s.busy      = 1'b1;
               next_s.convStart = 1'b1;
               next_s.intN      = 1'b1;
               if (s.wrByte[SinglePos]) begin
                  next_s.posSel    = 8'(8'h01 << newChan) & ChanMask;
                  next_s.negSel    = 8'h00;
                  next_s.negCommon = 1'b1;
               end else begin
                  next_s.posSel    = 8'(8'h01 << posIdx) & ChanMask;
                  next_s.negSel    = 8'(8'h01 << negIdx) & ChanMask;
                  next_s.negCommon = 1'b0;
               end
            end
            default: begin
               next_s.standby = s.standby;
            end
         endcase
      end else if (wrRise && s.busy && newMode == PwrFullDown) begin
         // shutdown asked mid-conversion waits for the result
         next_s.shutPending = 1'b1;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s <= ResetState;
      end else begin
         s <= next_s;
      end
   end

   // port outputs, all straight from the state register
   assign port.devData   = s.dataOut;
   assign port.devDataOe = s.dataOe;
   assign port.intN      = s.intN;

   // analog core outputs
   assign convStart   = s.convStart;
   assign extClock    = s.extClock;
   assign acqExternal = s.acqExt;
   assign standby     = s.standby;
   assign shutdown    = s.shutdown;
   assign posSel      = s.posSel;
   assign negSel      = s.negSel;
   assign negCommon   = s.negCommon;

endmodule : adc_port_device

// >>> rtl/adc_port_host.sv
// host end: reset and settling waits, control byte writes and two-byte result reads
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module adc_port_host
   import adc_port_pkg::*;
#(
   parameter int SettleCycles = SettleIntCycles
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // parallel port
   adc_port_if.host         port,
   // software register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [15:0] regRdata
);

   typedef struct packed {
      host_state_e state;
      logic [15:0] cnt;
      logic        settling;
      logic        csN;
      logic        wrN;
      logic        rdN;
      logic        hbs;
      logic [7:0]  dataOut;
      logic        dataOe;
      logic [7:0]  cmd;
      logic [7:0]  loByte;
      logic [15:0] result;
      logic        valid;
      logic [15:0] rdata;
   } host_state_s;

   localparam host_state_s ResetState = '{state: H_RESET, csN: 1'b1, wrN: 1'b1,
                                          rdN: 1'b1, default: '0};
   localparam logic [15:0] ResetLast  = 16'(ResetWaitCycles - 1);
   localparam logic [15:0] SettleLast = 16'(SettleCycles - 1);
   localparam logic [15:0] StrobeLast = 16'(StrobeCycles - 1);

   host_state_s s;
   host_state_s next_s;
   logic        cmdIsDown;

   // a power-down byte starts no conversion, so no result is awaited
   assign cmdIsDown = !s.cmd[PwrModeHiPos];

   // next-state logic
   always_comb begin
      next_s       = s;
      next_s.rdata = 16'h0000;
      next_s.cnt   = s.cnt + 16'h0001;

      // register reads answer one cycle later
      if (regRead) begin
         case (regAddr)
            RegStatus: begin
               next_s.rdata[StatBusyPos]   = (s.state != H_IDLE);
               next_s.rdata[StatValidPos]  = s.valid;
               next_s.rdata[StatSettlePos] = s.settling;
            end
            RegResult: next_s.rdata = s.result;
            default:   next_s.rdata = 16'h0000;
         endcase
      end

      case (s.state)
         H_RESET: begin
            // no access during the internal reset time
            if (s.cnt == ResetLast) begin
               next_s.state    = H_WRITE;
               next_s.settling = 1'b1;
               next_s.cmd      = StandbyByte;
               next_s.cnt      = 16'h0000;
               next_s.csN      = 1'b0;
               next_s.wrN      = 1'b0;
               next_s.dataOut  = StandbyByte;
               next_s.dataOe   = 1'b1;
            end
         end
         H_WRITE: begin
            // byte on the pins for the whole low strobe
            if (s.cnt == StrobeLast) begin
               next_s.csN    = 1'b1;
               next_s.wrN    = 1'b1;
               next_s.dataOe = 1'b0;
               next_s.cnt    = 16'h0000;
               if (s.settling) begin
                  next_s.state = H_SETTLE;
               end else if (cmdIsDown) begin
                  next_s.state = H_IDLE;
               end else begin
                  next_s.state = H_WAIT;
               end
            end
         end
         H_SETTLE: begin
            // reference settles while the converter idles in standby
            if (s.cnt == SettleLast) begin
               next_s.state    = H_IDLE;
               next_s.settling = 1'b0;
            end
         end
         H_IDLE: begin
            if (regWrite && regAddr == RegCtrl) begin
               next_s.state   = H_WRITE;
               next_s.cmd     = regWdata[7:0];
               next_s.cnt     = 16'h0000;
               next_s.csN     = 1'b0;
               next_s.wrN     = 1'b0;
               next_s.dataOut = regWdata[7:0];
               next_s.dataOe  = 1'b1;
               next_s.valid   = 1'b0;
            end
         end
         H_WAIT: begin
            // done output low marks a fresh result
            if (!port.intN) begin
               next_s.state = H_READ_LO;
               next_s.cnt   = 16'h0000;
               next_s.csN   = 1'b0;
               next_s.rdN   = 1'b0;
               next_s.hbs   = 1'b0;
            end
         end
         H_READ_LO: begin
            if (s.cnt == StrobeLast) begin
               next_s.loByte = port.busData;
               next_s.state  = H_READ_HI;
               next_s.cnt    = 16'h0000;
               next_s.hbs    = 1'b1;
            end
         end
         H_READ_HI: begin
            // high byte is already sign filled in bipolar mode
            if (s.cnt == StrobeLast) begin
               next_s.result = {port.busData, s.loByte};
               next_s.valid  = 1'b1;
               next_s.state  = H_IDLE;
               next_s.csN    = 1'b1;
               next_s.rdN    = 1'b1;
               next_s.hbs    = 1'b0;
            end
         end
         default: begin
            next_s = ResetState;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s <= ResetState;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign port.csN         = s.csN;
   assign port.wrN         = s.wrN;
   assign port.rdN         = s.rdN;
   assign port.highByteSel = s.hbs;
   assign port.hostData    = s.dataOut;
   assign port.hostDataOe  = s.dataOe;
   assign regRdata         = s.rdata;

endmodule : adc_port_host

// >>> tb/adc_port_asserts.sv
// concurrent checks on the parallel port wires between converter and host
`timescale 1ns/1ps
module adc_port_asserts
   import adc_port_pkg::*;
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       resetn,
   // port wires
   input wire logic       csN,
   input wire logic       wrN,
   input wire logic       rdN,
   input wire logic       highByteSel,
   input wire logic [7:0] hostData,
   input wire logic       hostDataOe,
   input wire logic [7:0] devData,
   input wire logic       devDataOe,
   input wire logic       intN,
   input wire logic [7:0] busData
);
   logic [7:0] ctrlByte;
   logic       prevWr;
   logic [9:0] rstCnt;
   logic       wrEnd;

   // remember the last written byte; it decides how a high byte must be filled
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrlByte <= 8'h00;
         prevWr   <= 1'b0;
         rstCnt   <= 10'h000;
      end else begin
         prevWr <= !csN && !wrN;
         if (!csN && !wrN) begin
            ctrlByte <= busData;
         end
         if (rstCnt != 10'h3ff) begin
            rstCnt <= rstCnt + 10'h001;  // saturates, only the first wait matters
         end
      end
   end
   assign wrEnd = prevWr && !(!csN && !wrN);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_rd_drive; (!csN && !rdN) |=> devDataOe; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("bus not driven on read");
   property p_drive_cause; devDataOe |-> $past(!csN && !rdN); endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("bus driven unasked");
   property p_release; csN |=> !devDataOe; endproperty
   a_release: assert property (p_release) else $error("bus held while deselected");
   property p_no_clash; !(devDataOe && hostDataOe); endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive the bus");
   property p_uni_fill;
      (devDataOe && $past(highByteSel) && ctrlByte[UnipolarPos]) |-> devData[7:2] == 6'h00;
   endproperty
   a_uni_fill: assert property (p_uni_fill) else $error("unipolar fill not zero");
   property p_bip_fill;
      (devDataOe && $past(highByteSel) && !ctrlByte[UnipolarPos])
         |-> devData[7:2] == {6{devData[1]}};
   endproperty
   a_bip_fill: assert property (p_bip_fill) else $error("bipolar fill not sign");
   property p_wr_hold; $fell(wrN) |=> (!wrN && $stable(hostData)) ##1 wrN; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write strobe shape wrong");
   property p_wr_drive; (!csN && !wrN) |-> hostDataOe && busData == hostData; endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("byte not on bus");
   property p_int_reset; disable iff (1'b0) !resetn |=> intN; endproperty
   a_int_reset: assert property (p_int_reset) else $error("done low after reset");
   property p_pd_quiet; (wrEnd && !ctrlByte[PwrModeHiPos]) |-> intN [*8]; endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("done in power down");
   property p_reset_wait; !wrN |-> rstCnt >= ResetWaitCycles; endproperty
   a_reset_wait: assert property (p_reset_wait) else $error("write too soon");
endmodule : adc_port_asserts

// >>> tb/tb.sv
// register-level test of host and converter ends joined by the parallel port
`timescale 1ns/1ps
module tb;
   import adc_port_pkg::*;
   logic        sys_clk;
   logic        resetn;
   logic [3:0]  regAddr;
   logic [15:0] regWdata;
   logic [15:0] regRdata;
   logic        regWrite;
   logic        regRead;
   logic        coreDone;
   logic [9:0]  coreCode;
   logic        convStart, extClock, acqExternal, standby, shutdown, negCommon;
   logic [7:0]  posSel, negSel;
   logic [7:0]  posSel4, negSel4;
   logic [2:0]  coreCnt;
   logic [15:0] lastRes;
   logic        expExt;
   int          n_errors, checks, nStarts;

   adc_port_if port();
   adc_port_device i_adc_port_device (.sys_clk(sys_clk), .resetn(resetn), .port(port),
      .convStart(convStart), .extClock(extClock), .acqExternal(acqExternal),
      .standby(standby), .shutdown(shutdown), .posSel(posSel), .negSel(negSel),
      .negCommon(negCommon), .coreDone(coreDone), .coreCode(coreCode));
   adc_port_host #(.SettleCycles(20)) i_adc_port_host (.sys_clk(sys_clk), .resetn(resetn),
      .port(port), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata));
   adc_port_asserts i_asserts (.sys_clk(sys_clk), .resetn(resetn), .csN(port.csN),
      .wrN(port.wrN), .rdN(port.rdN), .highByteSel(port.highByteSel),
      .hostData(port.hostData), .hostDataOe(port.hostDataOe), .devData(port.devData),
      .devDataOe(port.devDataOe), .intN(port.intN), .busData(port.busData));

   // four-channel build on a twin port; same orders and core answers keep it in step
   adc_port_if port4();
   adc_port_device #(.EightChannel(1'b0)) i_adc_port_device_4 (.sys_clk(sys_clk),
      .resetn(resetn), .port(port4), .convStart(), .extClock(), .acqExternal(),
      .standby(), .shutdown(), .posSel(posSel4), .negSel(negSel4), .negCommon(),
      .coreDone(coreDone), .coreCode(coreCode));
   adc_port_host #(.SettleCycles(20)) i_adc_port_host_4 (.sys_clk(sys_clk), .resetn(resetn),
      .port(port4), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata());

   always #10 sys_clk = ~sys_clk;

   // analog core stand-in: answers each start after six cycles
   always @(posedge sys_clk) begin
      if (!resetn) begin
         coreCnt  <= 3'h0;
         coreDone <= 1'b0;
      end else if (convStart === 1'b1) begin
         coreCnt  <= 3'h6;
         coreDone <= 1'b0;
         nStarts++;
      end else if (coreCnt == 3'h1) begin
         coreDone <= 1'b1;
         coreCnt  <= 3'h0;
      end else begin
         coreDone <= 1'b0;
         if (coreCnt != 3'h0) begin
            coreCnt <= coreCnt - 3'h1;
         end
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 d = regRdata;  // data stand only in the cycle after the strobe
   endtask : reg_rd

   // poll the busy bit with a bound so a stuck host cannot hang the run
   task automatic wait_idle;
      logic [15:0] s;
      int          k;
      s = 16'h0001;
      k = 0;
      while (s[StatBusyPos] !== 1'b0 && k < 2000) begin
         reg_rd(RegStatus, s);
         k++;
      end
      if (k >= 2000) chk(s, 16'h0000);
   endtask : wait_idle

   // one control byte, then every visible effect of it
   task automatic step(input logic [7:0] b, input logic [9:0] code);
      logic [15:0] r;
      logic [9:0]  v;
      int          n0;
      n0 = nStarts;
      @(posedge sys_clk);
      coreCode <= code;
      reg_wr(RegCtrl, {8'h00, b});
      wait_idle;
      if (b[7]) expExt = b[6];
      v = b[3] ? code : code ^ 10'h200;
      if (b[7]) lastRes = b[3] ? {6'h00, v} : {{6{v[9]}}, v};
      chk(16'(nStarts - n0), {15'h0, b[7]});
      chk({15'h0, standby}, {15'h0, b[7:6] == PwrStandby});
      chk({15'h0, shutdown}, {15'h0, b[7:6] == PwrFullDown});
      chk({15'h0, extClock}, {15'h0, expExt});
      // idle, settled, and a fresh result only after a converting byte
      reg_rd(RegStatus, r);
      chk(r, {14'h0, b[7], 1'b0});
      reg_rd(RegResult, r);
      chk(r, lastRes);
      if (b[7]) begin
         chk({15'h0, acqExternal}, {15'h0, b[5]});
         chk({15'h0, negCommon}, {15'h0, b[4]});
         chk({8'h0, posSel}, {8'h0, 8'h01 << b[2:0]});
         chk({8'h0, negSel}, b[4] ? 16'h0 : {8'h0, 8'h01 << (b[2:0] ^ 3'h1)});
         chk({8'h0, posSel4}, {8'h0, (8'h01 << b[2:0]) & FourChanMask});
         chk({8'h0, negSel4},
             b[4] ? 16'h0 : {8'h0, (8'h01 << (b[2:0] ^ 3'h1)) & FourChanMask});
      end
   endtask : step

   task automatic final_report;
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // watchdog: the tests need a few thousand cycles at most
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_errors++;
      final_report;
   end

   initial begin
      logic [15:0] r;
      logic [7:0]  b;
      sys_clk = 1'b0; resetn = 1'b0; regAddr = 4'h0; regWdata = 16'h0000;
      regWrite = 1'b0; regRead = 1'b0; coreDone = 1'b0; coreCode = 10'h000;
      expExt = 1'b1; lastRes = 16'h0000; n_errors = 0; checks = 0; nStarts = 0;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk({15'h0, extClock}, 16'h0001);
      chk({15'h0, port.intN}, 16'h0001);
      wait_idle;
      chk({15'h0, standby}, 16'h0001);
      chk(16'(nStarts), 16'h0000);
      // every channel code, single-ended unipolar then pseudo-differential bipolar
      for (int i = 0; i < 16; i++) begin
         b = (i < 8) ? (8'hd8 | 8'(i[2:0])) : (8'ha0 | 8'(i[2:0]));
         step(b, {i[0], 9'(i * 45)});
      end
      step(8'h00, 10'h155);
      step(8'hd3, 10'h2aa);
      step(8'h40, 10'h000);
      step(8'h9e, 10'h0ff);
      reg_rd(4'hc, r);
      chk(r, 16'h0000);
      chk({15'h0, port.intN}, 16'h0001);
      final_report;
   end
endmodule : tb
